// file: src/gsp_parser.sv
`timescale 1ns/1ps
`include "gsp_defs.svh"
module gsp_parser
   import gsp_pkg::*;
#(
   parameter logic [4:0] DEFAULT_ADDR = `GSP_DEFAULT_ADDR,
   parameter int NUM_SLOTS = 7
) (
   input wire logic refClk,
   input wire logic rst,
   input wire logic [7:0] dioIn,
   input wire logic dataValid,
   input wire logic atn,
   input wire logic ren,
   input wire logic [7:0] statusByte,
   input wire logic errSrqEnable,
   output logic [7:0] dioOut,
   output logic dioOe,
   output logic srqOut,
   output logic [3:0] function_o,
   output logic [3:0] range_o,
   output logic [1:0] zero_o,
   output logic zeroUseValue,
   output logic [6:0] filter_o,
   output logic filterOn,
   output logic [1:0] rate_o,
   output logic [2:0] trigSource,
   output logic trigOneShot,
   output logic readFromStore,
   output logic newReading,
   output logic illegal_command_letter_error,
   output logic illegal_command_option_error,
   output logic busError,
   output logic [4:0] busAddr
);
   // Addressing and poll state
   logic [4:0] addrReg;
   logic spModeReg, spModeNext;
   logic talkReg, talkNext;
   logic listenReg, listenNext;
   logic [7:0] dioOutReg;
   logic dioOeReg;
   logic srqReg, srqNext;
   // Parser state
   gsp_state_e stateReg, stateNext;
   gsp_slot_e curSlotReg, curSlotNext;
   gsp_opt_t optReg, optNext;
   logic badLetterReg, badLetterNext;
   logic badOptReg, badOptNext;
   logic renLostReg, renLostNext;
   logic [NUM_SLOTS-1:0] pendReg, pendNext;
   gsp_opt_t optBufReg [NUM_SLOTS];
   logic [2:0] execIdxReg, execIdxNext;
   // Settings
   logic [3:0] funcReg, rangeReg;
   logic [1:0] zeroReg, rateReg;
   logic [6:0] filtReg;
   logic [2:0] trigReg;
   logic rdgReg;
   // Decoded setting outputs kept in flops so no output is combinational
   logic zeroUseReg, filtOnReg;
   logic [2:0] trigSrcReg;
   logic newRdgReg, newRdgNext;
   logic errLetterReg, errOptReg, busErrReg;

   // ---------------------------------------------
   // Bus command decode
   // ---------------------------------------------
   wire cmdByte = dataValid && atn;
   wire datByte = dataValid && !atn;
   wire isSpe = cmdByte && dioIn == `GSP_CMD_SPE;
   wire isSpd = cmdByte && dioIn == `GSP_CMD_SPD;
   wire isMyTalk = cmdByte && dioIn == (`GSP_TALK_BASE | {3'h0, addrReg});
   wire isOtherTalk = cmdByte && dioIn[7:5] == 3'h2 && !isMyTalk;
   wire isMyListen = cmdByte && dioIn == (`GSP_LISTEN_BASE | {3'h0, addrReg});
   wire isUnl = cmdByte && dioIn == `GSP_UNL;
   wire rxByte = datByte && listenReg;
   wire isSpace = dioIn == `GSP_CH_SPACE;
   wire isExec = dioIn == `GSP_CH_EXEC;
   wire isDigit = dioIn >= `GSP_CH_ZERO && dioIn <= `GSP_CH_NINE;
   wire [3:0] digit = dioIn[3:0];
   wire [10:0] optWide = {4'h0, optReg} * 11'd10 + {7'h0, digit};
   wire optOverflow = optWide > 11'd99;

   // Letter lookup; valid flag plus slot
   logic letterOk;
   gsp_slot_e letterSlot;
   always_comb begin
      letterOk = 1'b1;
      letterSlot = GSP_B;
      case (dioIn)
         8'h42: letterSlot = GSP_B;
         8'h46: letterSlot = GSP_F;
         8'h50: letterSlot = GSP_P;
         8'h52: letterSlot = GSP_R;
         8'h53: letterSlot = GSP_S;
         8'h54: letterSlot = GSP_T;
         8'h5a: letterSlot = GSP_Z;
         default: letterOk = 1'b0;
      endcase
   end

   // Option limit per slot
   gsp_opt_t slotMax;
   always_comb begin
      case (curSlotReg)
         GSP_B: slotMax = `GSP_MAX_RDG;
         GSP_F: slotMax = `GSP_MAX_FUNC;
         GSP_P: slotMax = `GSP_MAX_FILT;
         GSP_R: slotMax = `GSP_MAX_RANGE;
         GSP_S: slotMax = `GSP_MAX_RATE;
         GSP_T: slotMax = `GSP_MAX_TRIG;
         GSP_Z: slotMax = `GSP_MAX_ZERO;
         default: slotMax = 7'h00;
      endcase
   end
   wire optBad = optReg > slotMax;
   wire closeCmd = stateReg == GSP_DIGITS;
   wire strBad = badLetterReg || badOptReg || (closeCmd && optBad);

   // ---------------------------------------------
   // Serial poll and addressing
   // ---------------------------------------------
   always_comb begin
      spModeNext = spModeReg;
      talkNext = talkReg;
      listenNext = listenReg;
      if (isSpe) spModeNext = 1'b1;
      if (isSpd) spModeNext = 1'b0;
      if (isMyTalk) talkNext = 1'b1;
      if (isOtherTalk) talkNext = 1'b0;
      if (isMyListen) listenNext = 1'b1;
      if (isUnl) listenNext = 1'b0;
   end
   // Poll answer ignores SRQ state so a poll works any time
   wire pollDrive = spModeReg && talkReg && !atn;

   // ---------------------------------------------
   // Command parser
   // ---------------------------------------------
   always_comb begin
      stateNext = stateReg;
      curSlotNext = curSlotReg;
      optNext = optReg;
      badLetterNext = badLetterReg;
      badOptNext = badOptReg;
      renLostNext = renLostReg;
      pendNext = pendReg;
      execIdxNext = execIdxReg;
      case (stateReg)
         GSP_IDLE, GSP_LETTER, GSP_DIGITS: begin
            if (rxByte && !isSpace) begin
               if (!ren) renLostNext = 1'b1;
               if (isExec) begin
                  badOptNext = badOptReg || (closeCmd && optBad);
                  stateNext = GSP_EXEC;
                  execIdxNext = 3'h0;
               end else if (stateReg == GSP_LETTER && !isDigit) begin
                  badOptNext = 1'b1;
                  stateNext = GSP_IDLE;
               end else if (isDigit && stateReg != GSP_IDLE) begin
                  optNext = optOverflow ? 7'h7f : optWide[6:0];
                  stateNext = GSP_DIGITS;
               end else if (isDigit) begin
                  badLetterNext = 1'b1;
               end else begin
                  // New letter closes any command in progress
                  if (closeCmd && optBad) badOptNext = 1'b1;
                  if (!letterOk) badLetterNext = 1'b1;
                  curSlotNext = letterSlot;
                  optNext = 7'h00;
                  stateNext = letterOk ? GSP_LETTER : GSP_IDLE;
               end
            end
         end
         GSP_EXEC: begin
            // One slot per cycle in slot order, which is letter order
            if (execIdxReg == 3'(NUM_SLOTS - 1) || strBad || renLostReg) begin
               stateNext = GSP_IDLE;
               pendNext = '0;
               badLetterNext = 1'b0;
               badOptNext = 1'b0;
               renLostNext = 1'b0;
            end else begin
               execIdxNext = execIdxReg + 3'h1;
            end
         end
         default: stateNext = GSP_IDLE;
      endcase
      // Store the finished command in its slot when the next token closes it
      if (rxByte && !isSpace && closeCmd && !optBad && !(isDigit)) pendNext[curSlotReg] = 1'b1;
      if (stateReg == GSP_EXEC) pendNext = (stateNext == GSP_IDLE) ? '0 : pendReg;
   end
   wire storeOpt = rxByte && !isSpace && closeCmd && !optBad && !isDigit;
   wire execOk = stateReg == GSP_EXEC && !strBad && !renLostReg;
   wire slotRun = execOk && pendReg[execIdxReg];
   wire execDone = stateReg == GSP_EXEC && stateNext == GSP_IDLE;
   wire errEvent = execDone && strBad && !renLostReg;
   assign newRdgNext = slotRun;
   // A new error in the poll read cycle wins over the clear
   assign srqNext = (srqReg && !pollDrive) || (errEvent && errSrqEnable);

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge refClk) begin
      if (rst) begin
         addrReg <= DEFAULT_ADDR;
         spModeReg <= 1'b0;
         talkReg <= 1'b0;
         listenReg <= 1'b0;
         dioOutReg <= 8'h00;
         dioOeReg <= 1'b0;
         srqReg <= 1'b0;
         stateReg <= GSP_IDLE;
         curSlotReg <= GSP_B;
         optReg <= 7'h00;
         badLetterReg <= 1'b0;
         badOptReg <= 1'b0;
         renLostReg <= 1'b0;
         pendReg <= '0;
         execIdxReg <= 3'h0;
         newRdgReg <= 1'b0;
      end else begin
         spModeReg <= spModeNext;
         talkReg <= talkNext;
         listenReg <= listenNext;
         dioOutReg <= pollDrive ? statusByte : 8'h00;
         dioOeReg <= pollDrive;
         srqReg <= srqNext;
         stateReg <= stateNext;
         curSlotReg <= curSlotNext;
         optReg <= optNext;
         badLetterReg <= badLetterNext;
         badOptReg <= badOptNext;
         renLostReg <= renLostNext;
         pendReg <= pendNext;
         execIdxReg <= execIdxNext;
         newRdgReg <= newRdgNext;
      end
   end

   always_ff @(posedge refClk) begin
      if (rst) begin
         for (int i = 0; i < NUM_SLOTS; i++) optBufReg[i] <= 7'h00;
      end else if (storeOpt) begin
         optBufReg[curSlotReg] <= optReg;
      end
   end

   // ---------------------------------------------
   // Settings applied at execute
   // ---------------------------------------------
   wire gsp_opt_t runOpt = optBufReg[execIdxReg];
   always_ff @(posedge refClk) begin
      if (rst) begin
         funcReg <= `GSP_RST_FUNC;
         rangeReg <= `GSP_RST_RANGE;
         zeroReg <= `GSP_RST_ZERO;
         filtReg <= `GSP_RST_FILT;
         rateReg <= `GSP_RST_RATE;
         trigReg <= `GSP_RST_TRIG;
         rdgReg <= `GSP_RST_RDG;
         zeroUseReg <= (`GSP_RST_ZERO == 2'h2);
         filtOnReg <= (`GSP_RST_FILT != 7'h00);
         trigSrcReg <= 3'(`GSP_RST_TRIG >> 1);
      end else if (slotRun) begin
         case (execIdxReg)
            3'(GSP_B): rdgReg <= runOpt[0];
            3'(GSP_F): funcReg <= runOpt[3:0];
            3'(GSP_P): begin
               filtReg <= runOpt;
               filtOnReg <= runOpt != 7'h00;
            end
            3'(GSP_R): rangeReg <= runOpt[3:0];
            3'(GSP_S): rateReg <= runOpt[1:0];
            3'(GSP_T): begin
               trigReg <= runOpt[2:0];
               trigSrcReg <= {1'b0, runOpt[2:1]};
            end
            3'(GSP_Z): begin
               zeroReg <= runOpt[1:0];
               zeroUseReg <= runOpt[1:0] == 2'h2;
            end
            default: rdgReg <= rdgReg;
         endcase
      end
   end

   // Error flags stay until the next execute, good or bad
   always_ff @(posedge refClk) begin
      if (rst) begin
         errLetterReg <= 1'b0;
         errOptReg <= 1'b0;
         busErrReg <= 1'b0;
      end else if (execDone) begin
         errLetterReg <= badLetterReg && !renLostReg;
         errOptReg <= (badOptReg || (closeCmd && optBad)) && !renLostReg;
         busErrReg <= renLostReg;
      end
   end

   assign dioOut = dioOutReg;
   assign dioOe = dioOeReg;
   assign srqOut = srqReg;
   assign function_o = funcReg;
   assign range_o = rangeReg;
   assign zero_o = zeroReg;
   assign zeroUseValue = zeroUseReg;
   assign filter_o = filtReg;
   assign filterOn = filtOnReg;
   assign rate_o = rateReg;
   assign trigSource = trigSrcReg;
   assign trigOneShot = trigReg[0];
   assign readFromStore = rdgReg;
   assign newReading = newRdgReg;
   assign illegal_command_letter_error = errLetterReg;
   assign illegal_command_option_error = errOptReg;
   assign busError = busErrReg;
   assign busAddr = addrReg;
endmodule : gsp_parser

// file: src/gsp_defs.svh
`ifndef GSP_DEFS_SVH
`define GSP_DEFS_SVH
// Bus command bytes (ATN true)
`define GSP_CMD_SPE 8'h18
`define GSP_CMD_SPD 8'h19
`define GSP_UNT 8'h5f
`define GSP_UNL 8'h3f
`define GSP_TALK_BASE 8'h40
`define GSP_LISTEN_BASE 8'h20
`define GSP_DEFAULT_ADDR 5'h0a
// Characters
`define GSP_CH_EXEC 8'h58
`define GSP_CH_SPACE 8'h20
`define GSP_CH_ZERO 8'h30
`define GSP_CH_NINE 8'h39
// Option limits
`define GSP_MAX_FUNC 7'h0d
`define GSP_MAX_RANGE 7'h08
`define GSP_MAX_ZERO 7'h02
`define GSP_MAX_FILT 7'h63
`define GSP_MAX_RATE 7'h03
`define GSP_MAX_TRIG 7'h07
`define GSP_MAX_RDG 7'h01
// Reset values of settings
`define GSP_RST_FUNC 4'h0
`define GSP_RST_RANGE 4'h5
`define GSP_RST_ZERO 2'h0
`define GSP_RST_FILT 7'h00
`define GSP_RST_RATE 2'h3
`define GSP_RST_TRIG 3'h6
`define GSP_RST_RDG 1'h0
`endif

// file: src/gsp_pkg.sv
package gsp_pkg;
   // Slot index per command letter, alphabetical
   typedef enum logic [2:0] {
      GSP_B = 3'h0,
      GSP_F = 3'h1,
      GSP_P = 3'h2,
      GSP_R = 3'h3,
      GSP_S = 3'h4,
      GSP_T = 3'h5,
      GSP_Z = 3'h6
   } gsp_slot_e;
   typedef enum logic [1:0] {
      GSP_IDLE = 2'b00,
      GSP_LETTER = 2'b01,
      GSP_DIGITS = 2'b11,
      GSP_EXEC = 2'b10
   } gsp_state_e;
   typedef logic [6:0] gsp_opt_t;
endpackage : gsp_pkg

// file: sim/gsp_parser_assertions.sv
`timescale 1ns/1ps
`include "gsp_defs.svh"
module gsp_parser_assertions
   import gsp_pkg::*;
#(
   parameter logic [4:0] DEFAULT_ADDR = `GSP_DEFAULT_ADDR
) (
   input wire logic refClk,
   input wire logic rst,
   input wire logic [7:0] dioIn,
   input wire logic dataValid,
   input wire logic atn,
   input wire logic [7:0] statusByte,
   input wire logic errSrqEnable,
   input wire logic [7:0] dioOut,
   input wire logic dioOe,
   input wire logic srqOut,
   input wire logic [3:0] function_o,
   input wire logic [3:0] range_o,
   input wire logic [1:0] zero_o,
   input wire logic zeroUseValue,
   input wire logic [6:0] filter_o,
   input wire logic filterOn,
   input wire logic [1:0] rate_o,
   input wire logic [2:0] trigSource,
   input wire logic trigOneShot,
   input wire logic readFromStore,
   input wire logic newReading,
   input wire logic illegal_command_letter_error,
   input wire logic illegal_command_option_error,
   input wire logic busError,
   input wire logic [4:0] busAddr
);
   default clocking cb @(posedge refClk); endclocking
   default disable iff (rst);
   // ----
   // Bus state shadow
   // ----
   logic spm;
   logic tlk;
   logic [5:0] sinceX;
   wire cmdByte = dataValid && atn;
   wire polled = spm && tlk && !atn;
   wire [23:0] setv = {function_o, range_o, zero_o, filter_o, rate_o, trigSource, trigOneShot, readFromStore};
   wire [2:0] flagv = {illegal_command_letter_error, illegal_command_option_error, busError};
   always_ff @(posedge refClk) begin
      if (rst) begin
         spm <= 1'b0;
         tlk <= 1'b0;
         sinceX <= 6'h3f;
      end else begin
         if (cmdByte && dioIn == `GSP_CMD_SPE) spm <= 1'b1;
         if (cmdByte && dioIn == `GSP_CMD_SPD) spm <= 1'b0;
         if (cmdByte && dioIn[7:5] == 3'h2) tlk <= dioIn[4:0] == DEFAULT_ADDR;
         if (dataValid && !atn && dioIn == `GSP_CH_EXEC) sinceX <= 6'h00;
         else if (sinceX != 6'h3f) sinceX <= sinceX + 6'h01;
      end
   end
   a_poll_drive: assert property (polled |=> dioOe && dioOut == $past(statusByte))
      else $error("status byte not driven on poll");
   a_oe_quiet: assert property (!polled |=> !dioOe)
      else $error("data bus driven outside poll");
   a_out_idle: assert property (!dioOe |-> dioOut == 8'h00)
      else $error("data out not zero while idle");
   a_addr_fixed: assert property (busAddr == DEFAULT_ADDR)
      else $error("bus address wrong");
   a_srq_cause: assert property ($rose(srqOut) |-> $past(errSrqEnable))
      else $error("service request without enable");
   a_srq_poll: assert property ($rose(dioOe) |-> ##[0:2] !srqOut)
      else $error("service request not cleared by poll");
   a_exec_only: assert property (newReading || !$stable(setv) |-> sinceX inside {[6'h01:6'h0c]})
      else $error("settings changed outside execute");
   a_err_exec: assert property (!$stable(flagv) |-> sinceX inside {[6'h01:6'h0e]})
      else $error("error flags changed outside execute");
   a_decode_ok: assert property (zeroUseValue == (zero_o == 2'h2) && filterOn == (filter_o != 7'h00))
      else $error("zero or filter decode wrong");
   a_opt_limits: assert property (function_o <= 4'hd && range_o <= 4'h8 && filter_o <= 7'h63)
      else $error("setting beyond legal option");
   cover property (polled ##1 dioOe);
   cover property ($rose(srqOut));
   cover property ($rose(illegal_command_option_error));
   cover property (newReading ##1 newReading);
endmodule : gsp_parser_assertions

bind gsp_parser gsp_parser_assertions #(.DEFAULT_ADDR(DEFAULT_ADDR)) gsp_parser_assertions_i (.*);

// file: sim/gsp_ctrl_model.sv
`timescale 1ns/1ps
module gsp_ctrl_model (
   input wire logic refClk,
   output logic [7:0] dioIn,
   output logic dataValid,
   output logic atn,
   output logic ren
);
   initial begin
      dioIn = 8'h00;
      dataValid = 1'b0;
      atn = 1'b1;
      ren = 1'b1;
   end
   // One byte per handshake; released bus never shows the stale byte
   task automatic put(input logic a, input logic [7:0] b);
      @(posedge refClk);
      #1;
      atn = a;
      dioIn = b;
      dataValid = 1'b1;
      @(posedge refClk);
      #1;
      dataValid = 1'b0;
      dioIn = ~b;
   endtask : put
   task automatic setAtn(input logic a);
      @(posedge refClk);
      #1;
      atn = a;
   endtask : setAtn
   task automatic setRen(input logic r);
      @(posedge refClk);
      #1;
      ren = r;
   endtask : setRen
endmodule : gsp_ctrl_model

// file: sim/gsp_parser_bench.sv
`timescale 1ns/1ps
`include "gsp_defs.svh"
module gsp_parser_bench;
   logic refClk, rst, dataValid, atn, ren, errSrqEnable, dioOe, srqOut, zeroUseValue, filterOn, trigOneShot;
   logic readFromStore, newReading, illegal_command_letter_error, illegal_command_option_error, busError;
   logic [7:0] dioIn, statusByte, dioOut;
   logic [3:0] function_o, range_o;
   logic [1:0] zero_o, rate_o;
   logic [6:0] filter_o;
   logic [2:0] trigSource;
   logic [4:0] busAddr;
   int miscompares = 0, checked = 0, cycles = 0, nrCount = 0;
   wire [23:0] setv = {function_o, range_o, zero_o, filter_o, rate_o, trigSource, trigOneShot, readFromStore};
   wire [23:0] flagv = {20'h0, illegal_command_letter_error, illegal_command_option_error, busError, srqOut};
   wire [23:0] pollv = {15'h0, dioOe, dioOut};
   gsp_parser gsp_parser_i (.*);
   gsp_ctrl_model gsp_ctrl_model_i (.*);
   initial begin
      refClk = 1'b0;
      forever #50 refClk = ~refClk;
   end
   always @(posedge refClk) begin
      cycles++;
      if (newReading === 1'b1) nrCount++;
      if (cycles == 5000) begin
         miscompares++;
         end_sim();
      end
   end
   // ----
   // Shared tasks
   // ----
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic send(input string s);
      gsp_ctrl_model_i.put(1'b1, `GSP_LISTEN_BASE | 8'h0a);
      gsp_ctrl_model_i.setAtn(1'b0);
      foreach (s[i]) gsp_ctrl_model_i.put(1'b0, s[i]);
   endtask : send
   task automatic run(input string s);
      send(s);
      repeat (12) @(posedge refClk);
      #1;
   endtask : run
   task automatic talk(input logic [4:0] a);
      gsp_ctrl_model_i.put(1'b1, `GSP_TALK_BASE | {3'h0, a});
      gsp_ctrl_model_i.setAtn(1'b0);
      repeat (3) @(posedge refClk);
      #1;
   endtask : talk
   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   // ----
   // Scenarios
   // ----
   task automatic t_reset();
      chk("settings", {`GSP_RST_FUNC, `GSP_RST_RANGE, `GSP_RST_ZERO, `GSP_RST_FILT, `GSP_RST_RATE, 3'h3, 1'b0,
         `GSP_RST_RDG}, setv);
      chk("address", 24'h0a, {19'h0, busAddr});
      chk("flags", 24'h0, flagv);
   endtask : t_reset
   task automatic t_codes();
      logic [6:0] p;
      for (int k = 0; k < 14; k++) begin
         p = (k == 13) ? 7'h63 : 7'(k * 7);
         nrCount = 0;
         run($sformatf("B%0d T%0dS%0dP%0dZ%0dR%0dF%0dX", k % 2, k % 8, k % 4, p, k % 3, k % 9, k));
         chk("settings", {4'(k), 4'(k % 9), 2'(k % 3), p, 2'(k % 4), 3'(k % 8 / 2), 1'(k % 2), 1'(k % 2)},
            setv);
         chk("decode", {22'h0, k % 3 == 2, p != 7'h00}, {22'h0, zeroUseValue, filterOn});
         chk("readings", 24'h7, 24'(nrCount));
      end
   endtask : t_codes
   task automatic t_order();
      int bad = 0;
      send("Z2F3X");
      repeat (12) begin
         @(posedge refClk);
         #1;
         if (zero_o === 2'h2 && function_o !== 4'h3) bad++;
      end
      chk("order", 24'h0, 24'(bad));
      chk("function", 24'h3, {20'h0, function_o});
      chk("zero", 24'h2, {22'h0, zero_o});
   endtask : t_order
   task automatic t_buffer();
      run("F1");
      chk("function", 24'h3, {20'h0, function_o});
      run("X");
      chk("function", 24'h1, {20'h0, function_o});
      nrCount = 0;
      run("X");
      chk("readings", 24'h0, 24'(nrCount));
   endtask : t_buffer
   task automatic t_errors();
      run("F3E1X");
      chk("flags", 24'h8, flagv);
      chk("function", 24'h1, {20'h0, function_o});
      run("F15X");
      chk("flags", 24'h4, flagv);
      errSrqEnable = 1'b1;
      run("P100X");
      chk("flags", 24'h5, flagv);
      run("F2X");
      chk("flags", 24'h1, flagv);
      chk("function", 24'h2, {20'h0, function_o});
      gsp_ctrl_model_i.setRen(1'b0);
      run("F4X");
      chk("flags", 24'h3, flagv);
      chk("function", 24'h2, {20'h0, function_o});
      gsp_ctrl_model_i.setRen(1'b1);
   endtask : t_errors
   task automatic t_poll();
      statusByte = 8'ha5;
      gsp_ctrl_model_i.put(1'b1, `GSP_CMD_SPE);
      talk(5'h0a);
      chk("poll", 24'h1a5, pollv);
      chk("flags", 24'h2, flagv);
      talk(5'h05);
      chk("poll", 24'h0, pollv);
      talk(5'h0a);
      chk("poll", 24'h1a5, pollv);
      gsp_ctrl_model_i.put(1'b1, `GSP_CMD_SPD);
      gsp_ctrl_model_i.setAtn(1'b0);
      repeat (3) @(posedge refClk);
      #1;
      chk("poll", 24'h0, pollv);
   endtask : t_poll
   task automatic t_unlisten();
      string s = "F7X";
      gsp_ctrl_model_i.put(1'b1, `GSP_UNL);
      gsp_ctrl_model_i.setAtn(1'b0);
      foreach (s[i]) gsp_ctrl_model_i.put(1'b0, s[i]);
      repeat (12) @(posedge refClk);
      #1;
      chk("function", 24'h2, {20'h0, function_o});
   endtask : t_unlisten
   task automatic t_midreset();
      rst = 1'b1;
      repeat (2) @(posedge refClk);
      #1;
      rst = 1'b0;
      t_reset();
      chk("poll", 24'h0, pollv);
      run("F5X");
      chk("function", 24'h5, {20'h0, function_o});
   endtask : t_midreset
   initial begin
      rst = 1'b1;
      statusByte = 8'h00;
      errSrqEnable = 1'b0;
      repeat (5) @(posedge refClk);
      #1;
      rst = 1'b0;
      t_reset();
      t_codes();
      t_order();
      t_buffer();
      t_errors();
      t_poll();
      t_unlisten();
      t_midreset();
      end_sim();
   end
endmodule : gsp_parser_bench
